// *** shared/indicator_pkg.sv ***
// Constants, register layout and state carriers for the message indicator sequencer
package indicator_pkg;

   // Register byte addresses (word aligned)
   localparam logic [3:0] ADDR_LEVEL_RAMP = 4'h0;
   localparam logic [3:0] ADDR_BLANK_PULSE = 4'h4;
   localparam logic [3:0] ADDR_CONTROL = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hC;

   // Reset values
   localparam logic [7:0] LEVEL_RAMP_RESET = 8'h00;
   localparam logic [7:0] BLANK_PULSE_RESET = 8'h00;

   // Field positions
   localparam int RAMP_MSB = 7;
   localparam int RAMP_LSB = 6;
   localparam int COUNT_MSB = 5;
   localparam int COUNT_LSB = 3;
   localparam int LEVEL_MSB = 2;
   localparam int LEVEL_LSB = 0;
   localparam int BLANK_MSB = 7;
   localparam int BLANK_LSB = 4;
   localparam int PULSE_MSB = 3;
   localparam int PULSE_LSB = 0;

   // Clock rate and timing units
   localparam longint CLK_HZ = 25_000_000;
   localparam longint RAMP_UNIT_MS = 156;
   localparam longint PULSE_UNIT_MS = 32;
   localparam longint RAMP_UNIT_CYCLES = RAMP_UNIT_MS * CLK_HZ / 1000;
   localparam longint PULSE_UNIT_CYCLES = PULSE_UNIT_MS * CLK_HZ / 1000;

   // Current step in microamps, one step per code plus one
   localparam int CURRENT_STEP_UA = 2250;

   // Sequencer phases
   typedef enum logic [2:0] {
      PH_IDLE,
      PH_RAMP_UP,
      PH_PULSE_HIGH,
      PH_RAMP_DOWN,
      PH_PULSE_LOW,
      PH_BLANK
   } phase_e;

   // Whole state of the sequencer
   typedef struct packed {
      logic [7:0] level_ramp_reg;
      logic [7:0] blank_pulse_reg;
      logic enable_reg;
      logic ack_reg;
      logic [31:0] rdata_reg;
      phase_e phase_reg;
      logic [2:0] period_reg;
      logic [3:0] blank_reg;
      logic [7:0] led_level_reg;
      logic led_on_reg;
   } seq_state_s;

   // Current source drive
   typedef struct packed {
      logic on;
      logic [7:0] level;
   } led_drive_s;

endpackage

// *** hdl/interval_timer.sv ***
// Down counter that measures one interval of a given length in cycles
`timescale 1ns/10ps
`default_nettype none
module interval_timer #(
   parameter int WIDTH = 32
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic load,
   input wire logic [WIDTH-1:0] length,
   output logic done
);
   logic [WIDTH-1:0] count_reg; // Cycles left
   logic [WIDTH-1:0] count_next;

   // Load on request, otherwise count down to zero
   always_comb begin
      count_next = count_reg;
      if (load) begin
         count_next = length;
      end else if (count_reg != '0) begin
         count_next = count_reg - 1'b1;
      end
   end

   // Count register
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   // Last cycle of the interval; load stays out of it, as the user derives load from done
   assign done = (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// *** hdl/message_indicator_sequencer.sv ***
// Message indicator pattern sequencer with a classic Wishbone register slave
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RULE1: Current code steps 2.25 mA, reset 000
// RULE2: Ramp time 156, 312 or 624 ms
// RULE3: Cycle twice ramp plus pulse; blank multiplies
// RULE4: Blink register: blank multiplier, pulse time
// RULE5: Indicator register: ramp, periods, current code
// RULE6: Repeat burst then blank while enabled
module message_indicator_sequencer
   import indicator_pkg::*;
#(
   parameter int TW = 32,
   parameter logic [TW-1:0] RAMP_UNIT = TW'(RAMP_UNIT_CYCLES),
   parameter logic [TW-1:0] PULSE_UNIT = TW'(PULSE_UNIT_CYCLES)
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic led_on,
   output logic [7:0] led_level,
   output logic [2:0] indicator_current_code
);
   seq_state_s s_reg; // Registered state
   seq_state_s s_next; // Next state
   logic tmr_load; // Start a new interval
   logic [TW-1:0] tmr_len; // Interval length in cycles
   logic tmr_done; // Interval ends this cycle
   logic bus_req; // New bus access
   logic [1:0] ramp_code; // Ramp field
   logic [2:0] count_code; // Period count field
   logic [3:0] pulse_code; // Pulse field
   logic [3:0] blank_code; // Blank multiplier field
   logic [TW-1:0] ramp_len; // Ramp time in cycles
   logic [TW-1:0] pulse_len; // Pulse time in cycles
   logic [TW-1:0] blank_len; // Blank time in cycles
   logic pattern_ok; // Pattern has a nonzero burst
   led_drive_s drive; // Drive bundle

   // Fields of the two pattern registers
   // RULE5: indicator field split
   assign ramp_code = s_reg.level_ramp_reg[RAMP_MSB:RAMP_LSB];
   assign count_code = s_reg.level_ramp_reg[COUNT_MSB:COUNT_LSB];
   // RULE4: blink field split
   assign pulse_code = s_reg.blank_pulse_reg[PULSE_MSB:PULSE_LSB];
   assign blank_code = s_reg.blank_pulse_reg[BLANK_MSB:BLANK_LSB];

   // Ramp length: 156 ms doubled per code step, zero for code 00
   // RULE2: ramp time decode
   always_comb begin
      unique case (ramp_code)
         2'h0: ramp_len = '0;
         2'h1: ramp_len = RAMP_UNIT;
         2'h2: ramp_len = TW'(RAMP_UNIT << 1);
         2'h3: ramp_len = TW'(RAMP_UNIT << 2);
      endcase
   end

   // Pulse length is 32 ms per code step
   // RULE4: pulse time scaling
   assign pulse_len = TW'(PULSE_UNIT * pulse_code);

   // Blank time: one full active burst per multiplier step
   // RULE3: blank equals active times multiplier
   assign blank_len = TW'((TW'(ramp_len << 1) + TW'(pulse_len << 1)) * count_code);

   // A burst needs periods and a nonzero cycle
   assign pattern_ok = (count_code != 3'h0) && ((ramp_len != '0) || (pulse_len != '0));

   assign bus_req = wb_cyc_i && wb_stb_i && !s_reg.ack_reg;

   // Next state: bus slave and sequencer
   always_comb begin
      s_next = s_reg;
      tmr_load = 1'b0;
      tmr_len = '0;
      s_next.ack_reg = bus_req;
      // Register writes honour the low byte lane
      if (bus_req && wb_we_i && wb_sel_i[0]) begin
         unique case (wb_adr_i)
            ADDR_LEVEL_RAMP: s_next.level_ramp_reg = wb_dat_i[7:0];
            ADDR_BLANK_PULSE: s_next.blank_pulse_reg = wb_dat_i[7:0];
            ADDR_CONTROL: s_next.enable_reg = wb_dat_i[0];
            default: ;
         endcase
      end
      // Read data, unmapped reads return zero
      s_next.rdata_reg = '0;
      if (bus_req && !wb_we_i) begin
         unique case (wb_adr_i)
            ADDR_LEVEL_RAMP: s_next.rdata_reg = {24'h000000, s_reg.level_ramp_reg};
            ADDR_BLANK_PULSE: s_next.rdata_reg = {24'h000000, s_reg.blank_pulse_reg};
            ADDR_CONTROL: s_next.rdata_reg = {31'h00000000, s_reg.enable_reg};
            ADDR_STATUS: s_next.rdata_reg = {24'h000000, s_reg.led_on_reg, s_reg.phase_reg,
                                             1'b0, s_reg.period_reg};
            default: s_next.rdata_reg = '0;
         endcase
      end
      // Phase sequencing
      unique case (s_reg.phase_reg)
         PH_IDLE: begin
            s_next.led_level_reg = '0;
            s_next.led_on_reg = 1'b0;
            // RULE6: start a burst once enabled
            if (s_reg.enable_reg && pattern_ok) begin
               s_next.phase_reg = PH_RAMP_UP;
               s_next.period_reg = count_code;
               tmr_load = 1'b1;
               tmr_len = (ramp_len != '0) ? ramp_len : {{(TW-1){1'b0}}, 1'b1};
            end
         end
         PH_RAMP_UP: begin
            s_next.led_on_reg = 1'b1;
            // Level climbs one step per cycle until it reaches the programmed code plus one
            if (s_reg.led_level_reg < {5'h00, s_reg.level_ramp_reg[LEVEL_MSB:LEVEL_LSB]} + 8'h01) begin
               s_next.led_level_reg = s_reg.led_level_reg + 8'h01;
            end
            // RULE3: ramp then pulse at full level
            if (tmr_done) begin
               // RULE1: pulse at programmed level, even after a zero ramp
               s_next.led_level_reg = {5'h00, s_reg.level_ramp_reg[LEVEL_MSB:LEVEL_LSB]} + 8'h01;
               s_next.phase_reg = PH_PULSE_HIGH;
               tmr_load = 1'b1;
               tmr_len = (pulse_len != '0) ? pulse_len : {{(TW-1){1'b0}}, 1'b1};
            end
         end
         PH_PULSE_HIGH: begin
            if (tmr_done) begin
               s_next.phase_reg = PH_RAMP_DOWN;
               tmr_load = 1'b1;
               tmr_len = (ramp_len != '0) ? ramp_len : {{(TW-1){1'b0}}, 1'b1};
            end
         end
         PH_RAMP_DOWN: begin
            if (s_reg.led_level_reg != 8'h00) begin
               s_next.led_level_reg = s_reg.led_level_reg - 8'h01;
            end
            if (tmr_done) begin
               s_next.led_level_reg = '0;
               s_next.led_on_reg = 1'b0;
               s_next.phase_reg = PH_PULSE_LOW;
               tmr_load = 1'b1;
               tmr_len = (pulse_len != '0) ? pulse_len : {{(TW-1){1'b0}}, 1'b1};
            end
         end
         PH_PULSE_LOW: begin
            // RULE3: count periods of the active burst
            if (tmr_done) begin
               s_next.period_reg = s_reg.period_reg - 3'h1;
               tmr_load = 1'b1;
               if (s_reg.period_reg != 3'h1) begin
                  s_next.phase_reg = PH_RAMP_UP;
                  tmr_len = (ramp_len != '0) ? ramp_len : {{(TW-1){1'b0}}, 1'b1};
               end else if (blank_code != 4'h0) begin
                  s_next.phase_reg = PH_BLANK;
                  s_next.blank_reg = blank_code;
                  tmr_len = blank_len;
               end else begin
                  s_next.phase_reg = PH_IDLE;
                  tmr_load = 1'b0;
               end
            end
         end
         PH_BLANK: begin
            // RULE6: blank spans multiplier bursts, then repeat
            if (tmr_done) begin
               s_next.blank_reg = s_reg.blank_reg - 4'h1;
               if (s_reg.blank_reg != 4'h1) begin
                  tmr_load = 1'b1;
                  tmr_len = blank_len;
               end else begin
                  s_next.phase_reg = PH_IDLE;
               end
            end
         end
         default: s_next.phase_reg = PH_IDLE;
      endcase
      // Disabling drops the LED at once
      if (!s_reg.enable_reg) begin
         s_next.phase_reg = PH_IDLE;
         s_next.led_on_reg = 1'b0;
         s_next.led_level_reg = '0;
      end
   end

   // State register
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s_reg <= '{level_ramp_reg: LEVEL_RAMP_RESET, blank_pulse_reg: BLANK_PULSE_RESET,
                    enable_reg: 1'b0, ack_reg: 1'b0, rdata_reg: '0, phase_reg: PH_IDLE,
                    period_reg: 3'h0, blank_reg: 4'h0, led_level_reg: 8'h00, led_on_reg: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // Interval timer shared by all phases
   interval_timer #(.WIDTH(TW)) u_timer (
      .clk_sys(clk_sys),
      .reset(reset),
      .load(tmr_load),
      .length(tmr_len),
      .done(tmr_done)
   );

   // Drive outputs; level is in 2.25 mA steps (1 step = code 000)
   // RULE1: current code to level steps
   assign drive.on = s_reg.led_on_reg;
   assign drive.level = s_reg.led_level_reg;
   assign led_on = drive.on;
   assign led_level = drive.level;
   assign indicator_current_code = s_reg.level_ramp_reg[LEVEL_MSB:LEVEL_LSB];
   assign wb_ack_o = s_reg.ack_reg;
   assign wb_dat_o = s_reg.rdata_reg;

   // Ack comes exactly one cycle after a fresh request
   a_bus_ack_timing: assert property (@(posedge clk_sys) disable iff (reset) // RULE5
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("ack missing after request");

   // Level never exceeds the programmed code plus one
   a_level_bound: assert property (@(posedge clk_sys) disable iff (reset) // RULE1
      led_level <= {5'h00, indicator_current_code} + 8'h01)
      else $error("level above programmed current");

   // Reset value of current code
   a_current_reset: assert property (@(posedge clk_sys) // RULE1
      $fell(reset) |-> indicator_current_code == 3'h0)
      else $error("current code not zero after reset");

   // Blank phase keeps LED dark
   a_blank_dark: assert property (@(posedge clk_sys) disable iff (reset) // RULE3
      (s_reg.phase_reg == PH_BLANK) |-> !led_on)
      else $error("LED lit during blank");

   // Pulse high holds level steady
   a_pulse_steady: assert property (@(posedge clk_sys) disable iff (reset) // RULE2
      (s_reg.phase_reg == PH_PULSE_HIGH && $past(s_reg.phase_reg) == PH_PULSE_HIGH)
      |-> $stable(led_level))
      else $error("level moved during pulse");

   // Write of blink register lands next cycle
   a_blink_write: assert property (@(posedge clk_sys) disable iff (reset) // RULE4
      (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_BLANK_PULSE)
      |=> s_reg.blank_pulse_reg == $past(wb_dat_i[7:0]))
      else $error("blink register write lost");

   // Enabled with a valid pattern leaves idle next cycle
   a_burst_start: assert property (@(posedge clk_sys) disable iff (reset) // RULE6
      (s_reg.phase_reg == PH_IDLE && s_reg.enable_reg && pattern_ok && $stable(s_reg.enable_reg))
      |=> s_reg.phase_reg == PH_RAMP_UP || !s_reg.enable_reg)
      else $error("burst did not start");

   // Ramp down ends with LED off
   a_ramp_end_off: assert property (@(posedge clk_sys) disable iff (reset) // RULE3
      (s_reg.phase_reg == PH_RAMP_DOWN && tmr_done && s_reg.enable_reg) |=> !led_on && led_level == 8'h00)
      else $error("LED still on after ramp down");
endmodule
`default_nettype wire

// *** test/led_current_model.sv ***
// Behavioural model of the indicator LED fed by its current source
`timescale 1ns/10ps
`default_nettype none
module led_current_model
   import indicator_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic led_on,
   input wire logic [7:0] led_level,
   input wire logic clear_peak,
   output var int current_ua,
   output var int peak_ua,
   output logic burst_start
);
   logic [7:0] level_prev; // Level seen at the previous edge
   always_comb current_ua = (led_on === 1'b1) ? int'(led_level) * CURRENT_STEP_UA : 0;
   // Peak tracking and ramp start detection
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         peak_ua <= 0;
         level_prev <= 8'h00;
         burst_start <= 1'b0;
      end else begin
         burst_start <= (current_ua != 0) && (level_prev == 8'h00);
         level_prev <= (current_ua != 0) ? led_level : 8'h00;
         if (clear_peak) peak_ua <= 0;
         else if (current_ua > peak_ua) peak_ua <= current_ua;
      end
   end
endmodule
`default_nettype wire

// *** test/message_indicator_sequencer_tb_top.sv ***
// Self-checking bench for the message indicator sequencer
`timescale 1ns/10ps
`default_nettype none
module message_indicator_sequencer_tb_top
   import indicator_pkg::*;
;
   localparam int RU = 20; // Shortened ramp unit, cycles
   localparam int PU = 5; // Shortened pulse unit, cycles
   logic clk_sys, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, led_on, clear_peak, burst_start;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [7:0] led_level;
   logic [2:0] indicator_current_code;
   int current_ua, peak_ua, miscompares, tests_run, cyc_cnt;
   int starts[$]; // Cycle stamps of ramp starts
   message_indicator_sequencer #(.TW(32), .RAMP_UNIT(32'h14), .PULSE_UNIT(32'h5)) uut (.clk_sys(clk_sys),
      .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .led_on(led_on),
      .led_level(led_level), .indicator_current_code(indicator_current_code));
   led_current_model led (.clk_sys(clk_sys), .reset(reset), .led_on(led_on), .led_level(led_level),
      .clear_peak(clear_peak), .current_ua(current_ua), .peak_ua(peak_ua), .burst_start(burst_start));
   // Clock, 40 ns period
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // Cycle count and start stamps
   always @(posedge clk_sys) begin
      cyc_cnt <= cyc_cnt + 1;
      if (burst_start === 1'b1) starts.push_back(cyc_cnt);
   end
   task automatic final_report;
      $display("Counts: tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Spans allow a few cycles of phase hand-over
   task automatic check_span(input string name, input int exp, input int seen);
      tests_run++;
      if (seen < exp - 4 || seen > exp + 4) begin
         miscompares++;
         $display("Error %s expected %0d seen %0d", name, exp, seen);
      end
   endtask
   // One classic Wishbone cycle, held until ack
   task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {24'h000000, d};
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 100);
      q = wb_dat_o;
      if (n >= 100) check("wb_ack_o", 32'h1, 32'h0);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic run(input logic [7:0] lr, input logic [7:0] bp);
      wb(1'b1, ADDR_CONTROL, 8'h00, 4'h1);
      starts.delete();
      clear_peak <= 1'b1;
      wb(1'b1, ADDR_LEVEL_RAMP, lr, 4'h1);
      clear_peak <= 1'b0;
      wb(1'b1, ADDR_BLANK_PULSE, bp, 4'h1);
      wb(1'b1, ADDR_CONTROL, 8'h01, 4'h1);
   endtask
   task automatic wait_starts(input int k);
      int n;
      n = 0;
      while (starts.size() < k && n < 5000) begin
         @(posedge clk_sys);
         n++;
      end
      check("start_count", k, (starts.size() < k) ? starts.size() : k);
   endtask
   task automatic t_regs;
      wb(1'b0, ADDR_LEVEL_RAMP, 8'h00, 4'h1); check("level_reset", 32'h0, q);
      wb(1'b0, ADDR_BLANK_PULSE, 8'h00, 4'h1); check("blank_reset", 32'h0, q);
      wb(1'b0, ADDR_CONTROL, 8'h00, 4'h1); check("control_reset", 32'h0, q);
      wb(1'b0, ADDR_STATUS, 8'h00, 4'h1); check("status_idle", 32'h0, q);
      wb(1'b1, ADDR_LEVEL_RAMP, 8'hAD, 4'h1);
      wb(1'b0, ADDR_LEVEL_RAMP, 8'h00, 4'h1); check("level_rw", 32'hAD, q);
      check("current_code", 32'h5, {29'h0, indicator_current_code});
      wb(1'b1, ADDR_BLANK_PULSE, 8'h3C, 4'h1);
      wb(1'b1, ADDR_BLANK_PULSE, 8'hFF, 4'h0);
      wb(1'b0, ADDR_BLANK_PULSE, 8'h00, 4'h1); check("blank_rw", 32'h3C, q);
      wb(1'b1, 4'h1, 8'hFF, 4'h1);
      wb(1'b0, 4'h1, 8'h00, 4'h1); check("unmapped", 32'h0, q);
   endtask
   task automatic t_current;
      for (int c = 0; c < 8; c++) begin
         run({5'b01001, c[2:0]}, 8'h01);
         wait_starts(2);
         check("peak_ua", (c + 1) * 2250, peak_ua);
         check("current_code", c, {29'h0, indicator_current_code});
         wb(1'b1, ADDR_CONTROL, 8'h00, 4'h1);
         @(posedge clk_sys);
         check("off_ua", 32'h0, current_ua);
      end
   endtask
   task automatic t_timing;
      int tab[6][4] = '{'{1, 3, 2, 2}, '{2, 1, 2, 1}, '{3, 15, 1, 3}, '{1, 1, 3, 0}, '{1, 0, 2, 0}, '{0, 2, 1, 0}};
      int r, p, n, b, t, rc, pc;
      foreach (tab[i]) begin
         r = tab[i][0];
         p = tab[i][1];
         n = tab[i][2];
         b = tab[i][3];
         // Ramp doubles per code step, a zero ramp or pulse lasts one cycle
         rc = (r == 0) ? 1 : RU << (r - 1);
         pc = (p == 0) ? 1 : p * PU;
         t = 2 * rc + 2 * pc;
         run({r[1:0], n[2:0], 3'h2}, {b[3:0], p[3:0]});
         wait_starts(n + 1);
         if (n > 1 && starts.size() > 1) check_span("cycle_time", t, starts[1] - starts[0]);
         if (starts.size() > n) check_span("burst_span", n * t * (1 + b) + 1, starts[n] - starts[0]);
      end
      run(8'h42, 8'h01);
      repeat (300) @(posedge clk_sys);
      check("no_burst", 32'h0, starts.size());
   endtask
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, clear_peak} = 4'h0;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 40'h0;
      {miscompares, tests_run} = '0;
      reset = 1'b1;
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      t_regs;
      t_current;
      t_timing;
      final_report;
   end
   // Watchdog
   initial begin
      #2400000;
      miscompares++;
      final_report;
   end
endmodule
`default_nettype wire
